// ===== logic/tpir_sync.sv
// Two-flop synchroniser for one level from another clock domain.
// Assumes the input holds long enough to be seen by the destination clock.
`default_nettype none

module tpir_sync (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_reg;

  // First stage is read only by the second
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ===== logic/tpir_top.sv
// Trace port integration-test and identification registers with APB access.
// Assumes both trace sources share mclk; the trace clock pin is asynchronous.
//
// Operation
// RULE1: Valid readback bit 0 returns OR of both source valid inputs.
// RULE2: Mode field: 00 normal, 01 integration test, 10 data test, 11 unused.
// RULE3: Data test mode disables trace output; software reads port data registers.
// RULE4: Capability bit 11 reads one: NRZ serial output supported.
// RULE5: Capability bit 10 reads one: Manchester serial output supported.
// RULE6: Capability bit 9 reads zero: parallel trace modes supported.
// RULE7: Capability bits 8:6 read 010, four byte minimum buffer.
// RULE8: Capability bit 5 reads one: trace clock may be asynchronous.
// RULE9: Capability bits 4:0 read 00001: two trace inputs.
// RULE10: Read-only device type register classifies the unit as trace sink.
// RULE11: In integration test mode, ready control bit 0 drives both readies.
// RULE12: Data register read returns valids and counts, then discards data.
// RULE13: Reserved bits read zero; writes to them have no effect.
`default_nettype none

module tpir_top #(
  parameter logic [7:0] DEV_TYPE = tpir_pkg::DEV_TYPE_DEFAULT
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_source_valid_in,
  input wire logic [7:0] first_source_data_in,
  input wire logic second_source_valid_in,
  input wire logic [7:0] second_source_data_in,
  output logic [1:0] source_ready_outputs,
  input wire logic trace_port_clock_in,
  output logic [7:0] trace_data_out,
  output logic trace_out_valid,
  output logic trace_out_enable
);

  // ------------------------------------------------------------
  // Trace clock edge detection
  // ------------------------------------------------------------
  logic tclk_sync;
  logic tclk_last_reg;
  logic tclk_rise;

  tpir_sync u_tclk_sync (
    .mclk(mclk),
    .rstn(rstn),
    .async_in(trace_port_clock_in),
    .sync_out(tclk_sync)
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tclk_last_reg <= 1'b0;
    end else begin
      tclk_last_reg <= tclk_sync;
    end
  end

  assign tclk_rise = tclk_sync & ~tclk_last_reg;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [1:0] mode_reg;
  logic ready_ctl_reg;
  logic wr_done;
  logic setup_rd;

  assign wr_done = psel & penable & pready & pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;

  // RULE2 RULE13 mode write filter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= tpir_pkg::MODE_RESET;
    end else if (wr_done && paddr == tpir_pkg::ADDR_MODE &&
                 pwdata[tpir_pkg::MODE_MSB:0] != tpir_pkg::MODE_RSVD) begin
      mode_reg <= pwdata[tpir_pkg::MODE_MSB:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ready_ctl_reg <= tpir_pkg::READY_CTL_RESET;
    end else if (wr_done && paddr == tpir_pkg::ADDR_READY) begin
      ready_ctl_reg <= pwdata[tpir_pkg::READY_CTL_BIT];
    end
  end

  // ------------------------------------------------------------
  // Per-port capture
  // ------------------------------------------------------------
  tpir_pkg::tpir_beat_t src [2];
  tpir_pkg::tpir_port_t port_reg [2];
  logic [1:0] take;
  logic [1:0] clr;
  logic [1:0] cnt_next_full;
  logic [1:0] pick;

  assign src[0] = '{valid: first_source_valid_in, data: first_source_data_in};
  assign src[1] = '{valid: second_source_valid_in, data: second_source_data_in};

  // Normal mode: one beat per rising trace clock edge, first source has priority
  assign pick[0] = tclk_rise & src[0].valid;
  assign pick[1] = tclk_rise & ~src[0].valid & src[1].valid;

  // RULE12 read clears counts
  assign clr[0] = setup_rd && paddr == tpir_pkg::ADDR_DATA1 &&
                  mode_reg == tpir_pkg::MODE_DTEST;
  assign clr[1] = setup_rd && paddr == tpir_pkg::ADDR_DATA2 &&
                  mode_reg == tpir_pkg::MODE_DTEST;

  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_port
    tpir_pkg::tpir_port_t port_next;

    assign take[gi] = src[gi].valid & source_ready_outputs[gi];

    // RULE3 RULE12 capture, new beat wins over read clear
    always_comb begin
      port_next = port_reg[gi];
      if (clr[gi]) begin
        port_next = '0;
      end
      if (take[gi] && mode_reg == tpir_pkg::MODE_DTEST &&
          port_next.cnt != tpir_pkg::CNT_FULL) begin
        port_next.data[8 * port_next.cnt +: 8] = src[gi].data;
        port_next.cnt = port_next.cnt + 2'h1;
      end
    end

    assign cnt_next_full[gi] = port_next.cnt == tpir_pkg::CNT_FULL;

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        port_reg[gi] <= '0;
      end else begin
        port_reg[gi] <= port_next;
      end
    end
  end

  // ------------------------------------------------------------
  // Source ready outputs
  // ------------------------------------------------------------
  logic [1:0] ready_next;

  always_comb begin
    unique case (mode_reg)
      tpir_pkg::MODE_ITEST: begin
        // RULE11 both readies from control bit
        ready_next = {2{ready_ctl_reg}};
      end
      tpir_pkg::MODE_DTEST: begin
        // Stall a port once its three-byte holding area is full
        ready_next = ~cnt_next_full;
      end
      default: begin
        ready_next = pick;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      source_ready_outputs <= 2'h0;
    end else begin
      source_ready_outputs <= ready_next;
    end
  end

  // ------------------------------------------------------------
  // Trace output
  // ------------------------------------------------------------
  // RULE3 output off in data test mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trace_out_valid <= 1'b0;
      trace_data_out <= 8'h00;
      trace_out_enable <= 1'b1;
    end else begin
      trace_out_enable <= mode_reg != tpir_pkg::MODE_DTEST;
      trace_out_valid <= (mode_reg == tpir_pkg::MODE_NORMAL) && (|take);
      if (mode_reg == tpir_pkg::MODE_NORMAL && |take) begin
        trace_data_out <= take[0] ? src[0].data : src[1].data;
      end
    end
  end

  // ------------------------------------------------------------
  // APB read decode and response
  // ------------------------------------------------------------
  logic [31:0] rd_value;
  logic hit;
  logic [31:0] data_status;

  assign data_status = {2'h0, src[1].valid, port_reg[1].cnt,
                        src[0].valid, port_reg[0].cnt, 24'h000000};

  always_comb begin
    rd_value = 32'h00000000;
    hit = 1'b1;
    unique case (paddr)
      tpir_pkg::ADDR_MODE: rd_value = {30'h00000000, mode_reg};
      tpir_pkg::ADDR_READY: rd_value = {31'h00000000, ready_ctl_reg};
      // RULE1 combined valid readback
      tpir_pkg::ADDR_VALID: rd_value = {31'h00000000, src[0].valid | src[1].valid};
      tpir_pkg::ADDR_DATA1: rd_value = data_status | {8'h00, port_reg[0].data};
      tpir_pkg::ADDR_DATA2: rd_value = data_status | {8'h00, port_reg[1].data};
      // RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 capability constant
      tpir_pkg::ADDR_CAP: rd_value = tpir_pkg::CAP_VALUE;
      // RULE10 device type
      tpir_pkg::ADDR_TYPE: rd_value = {24'h000000, DEV_TYPE};
      default: hit = 1'b0;
    endcase
  end

  // Answer one cycle after setup; no extra wait states
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= ~hit;
      prdata <= pwrite ? 32'h00000000 : rd_value;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence rd_setup(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  chk_valid_readback: assert property ( // RULE1
    rd_setup(tpir_pkg::ADDR_VALID) |=> pready &&
      prdata == {31'h0, $past(first_source_valid_in | second_source_valid_in)})
    else $error("valid readback mismatch");

  chk_mode_never_rsvd: assert property ( // RULE2
    wr_done && paddr == tpir_pkg::ADDR_MODE && pwdata[1:0] == 2'h3
      |=> mode_reg == $past(mode_reg))
    else $error("reserved mode accepted");

  chk_dtest_output_off: assert property ( // RULE3
    mode_reg == tpir_pkg::MODE_DTEST |=> !trace_out_enable && !trace_out_valid)
    else $error("trace output active in data test");

  chk_cap_nrz_bit: assert property ( // RULE4
    rd_setup(tpir_pkg::ADDR_CAP) |=> prdata[11])
    else $error("capability bit 11 not one");

  chk_cap_manch_bit: assert property ( // RULE5
    rd_setup(tpir_pkg::ADDR_CAP) |=> prdata[10])
    else $error("capability bit 10 not one");

  chk_cap_par_bit: assert property ( // RULE6
    rd_setup(tpir_pkg::ADDR_CAP) |=> !prdata[9])
    else $error("capability bit 9 not zero");

  chk_cap_buf_field: assert property ( // RULE7
    rd_setup(tpir_pkg::ADDR_CAP) |=> prdata[8:6] == 3'h2)
    else $error("buffer size field wrong");

  chk_cap_clk_inputs: assert property ( // RULE8 RULE9
    rd_setup(tpir_pkg::ADDR_CAP) |=> prdata[5] && prdata[4:0] == 5'h01
      && prdata[31:12] == 20'h0)
    else $error("clock or input count field wrong");

  chk_devtype_read: assert property ( // RULE10
    rd_setup(tpir_pkg::ADDR_TYPE) ##1 (psel && penable) |-> prdata == {24'h0, DEV_TYPE})
    else $error("device type mismatch");

  chk_ready_follow: assert property ( // RULE11
    mode_reg == tpir_pkg::MODE_ITEST ##1 mode_reg == tpir_pkg::MODE_ITEST
      |-> source_ready_outputs == {2{$past(ready_ctl_reg)}})
    else $error("readies do not follow control bit");

  chk_data_read_clear: assert property ( // RULE12
    clr[0] && !take[0] |=> port_reg[0].cnt == 2'h0 && port_reg[0].data == 24'h0)
    else $error("data read did not discard");

  chk_reserved_zero: assert property ( // RULE13
    psel && !penable && !pwrite &&
      (paddr == tpir_pkg::ADDR_MODE || paddr == tpir_pkg::ADDR_READY)
      |=> prdata[31:2] == 30'h0)
    else $error("reserved control bits not zero");

endmodule

`default_nettype wire

// ===== pkg/tpir_pkg.sv
// Package: register map, field layout and constants for the trace port
// integration and identification registers.
// Assumes a 32-bit APB slave with word-aligned registers in a 4 KB window.
`default_nettype none

package tpir_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_READY = 12'h004;
  localparam logic [11:0] ADDR_VALID = 12'h008;
  localparam logic [11:0] ADDR_DATA1 = 12'h00c;
  localparam logic [11:0] ADDR_DATA2 = 12'h010;
  localparam logic [11:0] ADDR_CAP = 12'h014;
  localparam logic [11:0] ADDR_TYPE = 12'h018;

  // ------------------------------------------------------------
  // Operating modes and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ITEST = 2'h1;
  localparam logic [1:0] MODE_DTEST = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic READY_CTL_RESET = 1'b0;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int MODE_MSB = 1;
  localparam int READY_CTL_BIT = 0;
  localparam int VALID_BIT = 0;
  localparam int D2_VALID_BIT = 29;
  localparam int D2_CNT_LSB = 27;
  localparam int D1_VALID_BIT = 26;
  localparam int D1_CNT_LSB = 24;
  localparam int DATA_MSB = 23;
  localparam logic [1:0] CNT_FULL = 2'h3;

  // ------------------------------------------------------------
  // Capability fields
  // ------------------------------------------------------------
  localparam logic CAP_NRZ = 1'b1;
  localparam logic CAP_MANCH = 1'b1;
  localparam logic CAP_PAR_RAZ = 1'b0;
  localparam logic [2:0] CAP_BUF = 3'h2;
  localparam logic CAP_ASYNC = 1'b1;
  localparam logic [4:0] CAP_INPUTS = 5'h01;
  localparam logic [31:0] CAP_VALUE = {20'h00000, CAP_NRZ, CAP_MANCH, CAP_PAR_RAZ,
                                       CAP_BUF, CAP_ASYNC, CAP_INPUTS};

  // Arbitrary neutral device type code
  localparam logic [7:0] DEV_TYPE_DEFAULT = 8'h5a;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tpir_beat_t;

  typedef struct packed {
    logic [1:0] cnt;
    logic [23:0] data;
  } tpir_port_t;

endpackage

`default_nettype wire

// ===== testbench/tpir_src_model.sv
// Partner model: two trace sources and the trace port clock pin.
// Assumes the bench sets req and run just after an mclk edge.
`default_nettype none

module tpir_src_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] req,
  input wire logic run,
  input wire logic [1:0] source_ready_outputs,
  output logic first_source_valid_in,
  output logic [7:0] first_source_data_in,
  output logic second_source_valid_in,
  output logic [7:0] second_source_data_in,
  output logic trace_port_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] vld_reg;
  logic [7:0] byte_reg [2];

  // ------------------------------------------------------------
  // Sources hold a byte until it is taken
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      vld_reg <= 2'h0;
      byte_reg[0] <= 8'h10;
      byte_reg[1] <= 8'h80;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!vld_reg[i]) begin
          vld_reg[i] <= req[i];
        end else if (source_ready_outputs[i]) begin
          byte_reg[i] <= byte_reg[i] + 8'h01;
          vld_reg[i] <= req[i];
        end
      end
    end
  end

  // Idle data inverted so a stale byte never passes
  assign first_source_valid_in = vld_reg[0];
  assign first_source_data_in = vld_reg[0] ? byte_reg[0] : ~byte_reg[0];
  assign second_source_valid_in = vld_reg[1];
  assign second_source_data_in = vld_reg[1] ? byte_reg[1] : ~byte_reg[1];

  // Trace clock runs only within a frame, phase unrelated to mclk
  initial begin
    trace_port_clock_in = 1'b0;
    #13;
    forever begin
      #40;
      trace_port_clock_in = run ? ~trace_port_clock_in : 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== testbench/tpir_top_tb.sv
// Testbench: register rows, trace forwarding, data test capture, reset.
// Assumes tpir_top and the source model share one 125 MHz clock.
`default_nettype none

module tpir_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] a;
    logic w;
    logic [31:0] wd;
    logic [1:0] req;
    logic [31:0] rd;
    logic err;
    logic [1:0] rdy;
  } tpir_row_t;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, run, rerr;
  logic first_source_valid_in, second_source_valid_in, trace_port_clock_in;
  logic trace_out_valid, trace_out_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [7:0] first_source_data_in, second_source_data_in, trace_data_out;
  logic [1:0] source_ready_outputs, req;
  int fail_count, compares;
  tpir_row_t rows [17] = '{
    '{12'h014, 1'b0, 32'h0, 2'h0, 32'h00000ca1, 1'b0, 2'h0},
    '{12'h014, 1'b1, 32'hffffffff, 2'h0, 32'h0, 1'b0, 2'h0},
    '{12'h014, 1'b0, 32'h0, 2'h0, 32'h00000ca1, 1'b0, 2'h0},
    '{12'h018, 1'b0, 32'h0, 2'h0, 32'h0000003c, 1'b0, 2'h0},
    '{12'h018, 1'b1, 32'h0, 2'h0, 32'h0, 1'b0, 2'h0},
    '{12'h018, 1'b0, 32'h0, 2'h0, 32'h0000003c, 1'b0, 2'h0},
    '{12'h01c, 1'b0, 32'h0, 2'h0, 32'h0, 1'b1, 2'h0},
    '{12'h000, 1'b1, 32'hfffffffd, 2'h0, 32'h0, 1'b0, 2'h0},
    '{12'h000, 1'b0, 32'h0, 2'h0, 32'h1, 1'b0, 2'h0},
    '{12'h000, 1'b1, 32'h3, 2'h0, 32'h0, 1'b0, 2'h0},
    '{12'h000, 1'b0, 32'h0, 2'h0, 32'h1, 1'b0, 2'h0},
    '{12'h004, 1'b1, 32'hffffffff, 2'h0, 32'h0, 1'b0, 2'h3},
    '{12'h004, 1'b0, 32'h0, 2'h0, 32'h1, 1'b0, 2'h3},
    '{12'h004, 1'b1, 32'h0, 2'h0, 32'h0, 1'b0, 2'h0},
    '{12'h008, 1'b0, 32'h0, 2'h0, 32'h0, 1'b0, 2'h0},
    '{12'h008, 1'b0, 32'h0, 2'h2, 32'h1, 1'b0, 2'h0},
    '{12'h008, 1'b0, 32'h0, 2'h3, 32'h1, 1'b0, 2'h0}
  };

  // Device type value is arbitrary
  tpir_top #(.DEV_TYPE(8'h3c)) i_dut (.mclk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .first_source_valid_in,
    .first_source_data_in, .second_source_valid_in, .second_source_data_in,
    .source_ready_outputs, .trace_port_clock_in, .trace_data_out,
    .trace_out_valid, .trace_out_enable);
  tpir_src_model i_src (.mclk, .rstn, .req, .run, .source_ready_outputs,
    .first_source_valid_in, .first_source_data_in, .second_source_valid_in,
    .second_source_data_in, .trace_port_clock_in);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Whole run is under three hundred cycles
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  initial begin
    {rstn, psel, penable, pwrite, run, req} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      req <= rows[i].req;
      apb(rows[i].a, rows[i].w, rows[i].wd);
      if (!rows[i].w) chk(rdata, rows[i].rd);
      chk({31'h0, rerr}, {31'h0, rows[i].err});
      repeat (2) @(posedge mclk);
      chk({30'h0, source_ready_outputs}, {30'h0, rows[i].rdy});
    end
    $display("register rows done");
    // Normal mode: req asks only the first source, yet both hold a valid byte; the first source's byte goes out on the first trace clock edge
    apb(12'h000, 1'b1, 32'h0);
    req <= 2'h1;
    run <= 1'b1;
    do begin
      @(posedge mclk);
    end while (trace_out_valid !== 1'b1);
    chk({24'h0, trace_data_out}, 32'h10);
    chk({31'h0, trace_out_enable}, 32'h1);
    @(posedge mclk);
    chk({31'h0, trace_out_valid}, 32'h0);
    run <= 1'b0;
    $display("forwarding test done");
    apb(12'h000, 1'b1, 32'h2);
    do begin
      @(posedge mclk);
    end while (first_source_data_in !== 8'h14);
    req <= 2'h0;
    chk({31'h0, trace_out_enable}, 32'h0);
    apb(12'h00c, 1'b0, 32'h0);
    chk(rdata, 32'h0f131211);
    do begin
      @(posedge mclk);
    end while (first_source_valid_in !== 1'b0);
    apb(12'h00c, 1'b0, 32'h0);
    chk(rdata, 32'h09000014);
    apb(12'h010, 1'b0, 32'h0);
    chk(rdata, 32'h08000080);
    $display("data test done");
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({29'h0, trace_out_enable, source_ready_outputs}, 32'h4);
    rstn <= 1'b1;
    apb(12'h000, 1'b0, 32'h0);
    chk(rdata, 32'h0);
    $display("reset test done");
    give_verdict();
  end
endmodule

`default_nettype wire
